// file: hdl/rxf_defines.vh
// constants for the receive data filter and bit clock recovery
`ifndef RXF_DEFINES_VH
`define RXF_DEFINES_VH
`define RXF_OVERSAMPLE 5'd29
`define RXF_HALF_BIT 5'd14
`define RXF_MODE_FAST 2'h0
`define RXF_MODE_SLOW 2'h1
`define RXF_MODE_AUTO 2'h2
`define RXF_FAST_STEP 5'd4
`define RXF_SLOW_STEP 5'd1
`define RXF_SLOW_WINDOW 5'd3
`define RXF_LOCK_COUNT 4'd8
`define RXF_MAJ_FAST 3'd3
`define RXF_MAJ_SLOW 3'd5
`define RXF_DIGITAL_MAX_BPS 32'd115200
`define RXF_ANALOG_MAX_BPS 32'd256000
`endif

// file: hdl/rxf_filter.v
// receive data filter, bit clock recovery and receive FIFO
`timescale 1ns/1ps
`include "rxf_defines.vh"

module rxf_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_wr)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end
endmodule // rxf_fifo

module rxf_filter #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
) (
	input wire CLK,
	input wire RST_N,
	input wire RAW_DATA,
	input wire SLICED_DATA,
	input wire OVERSAMPLE_TICK,
	input wire DIGITAL_MODE,
	input wire [1:0] RECOVERY_MODE,
	input wire FIFO_ENABLE,
	input wire FIFO_READY,
	output reg FIFO_DATA,
	output reg FIFO_VALID,
	output reg FIFO_OVERRUN,
	output reg DATA_OUT,
	output reg BIT_CLOCK,
	output reg LOCKED,
	output reg SLOW_ACTIVE
);
	// external pins pass three flops and a hold flop; a change is taken once stages two and three agree
	reg raw_s1, raw_s2, raw_s3, raw_q;
	reg sl_s1, sl_s2, sl_s3, sl_q;
	reg [4:0] hist;
	reg filt;
	reg filt_d;
	reg [4:0] phase;
	reg [3:0] lock_cnt;
	reg [1:0] mode_d;
	reg bit_strobe;
	reg bit_value;
	wire slow_mode;
	wire edge_seen;
	wire on_time;
	wire [2:0] ones;
	wire [2:0] maj;
	wire f_in_ready;
	wire f_out_valid;
	wire f_out_data;
	wire push;

	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			raw_s1 <= 1'b0; raw_s2 <= 1'b0; raw_s3 <= 1'b0; raw_q <= 1'b0;
			sl_s1 <= 1'b0; sl_s2 <= 1'b0; sl_s3 <= 1'b0; sl_q <= 1'b0;
		end
		else
		begin
			raw_s1 <= RAW_DATA;
			raw_s2 <= raw_s1;
			raw_s3 <= raw_s2;
			if (raw_s2 == raw_s3)
				raw_q <= raw_s3;
			sl_s1 <= SLICED_DATA;
			sl_s2 <= sl_s1;
			sl_s3 <= sl_s2;
			if (sl_s2 == sl_s3)
				sl_q <= sl_s3;
		end
	end

	// automatic mode uses fast behaviour until locked
	assign slow_mode = (RECOVERY_MODE == `RXF_MODE_SLOW) ||
		((RECOVERY_MODE == `RXF_MODE_AUTO) && LOCKED);
	// slow takes a wider majority: better noise immunity, more delay
	assign ones = {2'b00, hist[0]} + {2'b00, hist[1]} + {2'b00, hist[2]}
		+ (slow_mode ? ({2'b00, hist[3]} + {2'b00, hist[4]}) : 3'd0);
	assign maj = slow_mode ? `RXF_MAJ_SLOW : `RXF_MAJ_FAST;
	assign edge_seen = OVERSAMPLE_TICK && (filt != filt_d);
	// an edge is on time when it lands near the bit boundary (phase 0)
	assign on_time = (phase <= `RXF_SLOW_WINDOW) ||
		(phase >= `RXF_OVERSAMPLE - `RXF_SLOW_WINDOW);
	assign push = bit_strobe && FIFO_ENABLE && DIGITAL_MODE;

	// filter and recovery advance only on oversampling ticks at 29x bit rate
	always @(posedge CLK)
	begin
		if (!RST_N || !DIGITAL_MODE)
		begin
			hist <= 5'h00;
			filt <= 1'b0;
			filt_d <= 1'b0;
			phase <= 5'h00;
			lock_cnt <= 4'h0;
			mode_d <= 2'h0;
			LOCKED <= 1'b0;
			bit_strobe <= 1'b0;
			bit_value <= 1'b0;
			BIT_CLOCK <= 1'b0;
		end
		else
		begin
			bit_strobe <= 1'b0;
			if (OVERSAMPLE_TICK)
			begin
				hist <= {hist[3:0], raw_q};
				filt <= ({1'b0, ones} * 4'd2 > {1'b0, maj}) ? 1'b1 : 1'b0;
				filt_d <= filt;
				if (edge_seen)
				begin
					// nudge phase toward zero; slow steps are small
					if (phase < `RXF_HALF_BIT)
						phase <= (phase > (slow_mode ? `RXF_SLOW_STEP : `RXF_FAST_STEP)) ?
							phase - (slow_mode ? `RXF_SLOW_STEP : `RXF_FAST_STEP) : 5'h00;
					// compare by subtraction so the sum never wraps past phase 28
					else if (phase >= `RXF_OVERSAMPLE - 5'd1 -
						(slow_mode ? `RXF_SLOW_STEP : `RXF_FAST_STEP))
						phase <= 5'h00;
					else
						phase <= phase + (slow_mode ? `RXF_SLOW_STEP : `RXF_FAST_STEP) + 5'd1;
					if (on_time)
					begin
						if (lock_cnt == `RXF_LOCK_COUNT - 4'd1)
							LOCKED <= 1'b1;
						else
							lock_cnt <= lock_cnt + 4'd1;
					end
					else
					begin
						lock_cnt <= 4'h0;
						// selected slow mode tolerates less timing error than fast or automatic
						if (slow_mode && RECOVERY_MODE == `RXF_MODE_SLOW)
							LOCKED <= 1'b0;
					end
				end
				else
					phase <= (phase == `RXF_OVERSAMPLE - 5'd1) ? 5'h00 : phase + 5'd1;
				if (phase == `RXF_HALF_BIT)
				begin
					bit_strobe <= 1'b1;
					bit_value <= filt;
					BIT_CLOCK <= 1'b1;
				end
				else if (phase == 5'h00)
					BIT_CLOCK <= 1'b0;
			end
			// a new mode restarts acquisition, so automatic always begins fast
			mode_d <= RECOVERY_MODE;
			if (RECOVERY_MODE != mode_d)
			begin
				lock_cnt <= 4'h0;
				LOCKED <= 1'b0;
			end
		end
	end

	rxf_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.in_data(bit_value),
		.in_valid(push),
		.in_ready(f_in_ready),
		.out_data(f_out_data),
		.out_valid(f_out_valid),
		.out_ready(FIFO_READY && FIFO_VALID)
	);

	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			FIFO_DATA <= 1'b0;
			FIFO_VALID <= 1'b0;
			FIFO_OVERRUN <= 1'b0;
			DATA_OUT <= 1'b0;
			SLOW_ACTIVE <= 1'b0;
		end
		else
		begin
			// registered view; valid drops one cycle after each take
			FIFO_VALID <= f_out_valid && !(FIFO_READY && FIFO_VALID);
			FIFO_DATA <= f_out_data;
			FIFO_OVERRUN <= push && !f_in_ready;
			SLOW_ACTIVE <= DIGITAL_MODE && slow_mode;
			if (!DIGITAL_MODE)
				DATA_OUT <= sl_q;
			else if (!FIFO_ENABLE)
				DATA_OUT <= filt;
			else
				DATA_OUT <= 1'b0;
		end
	end
endmodule // rxf_filter

// file: tb/rxf_filter_asserts.sv
// port checker for the receive data filter
`timescale 1ns/1ps
module rxf_filter_asserts (
	input wire CLK,
	input wire RST_N,
	input wire OVERSAMPLE_TICK,
	input wire DIGITAL_MODE,
	input wire [1:0] RECOVERY_MODE,
	input wire FIFO_ENABLE,
	input wire FIFO_READY,
	input wire FIFO_DATA,
	input wire FIFO_VALID,
	input wire DATA_OUT,
	input wire BIT_CLOCK,
	input wire LOCKED,
	input wire SLOW_ACTIVE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_auto_lock;
		RECOVERY_MODE == 2'h2 && DIGITAL_MODE && $rose(LOCKED);
	endsequence
	property p_rise;
		$rose(BIT_CLOCK) |-> $past(OVERSAMPLE_TICK) && $past(DIGITAL_MODE);
	endproperty
	a_rise: assert property (p_rise) else $error("clock rise");
	property p_ana;
		(!DIGITAL_MODE) [*3] |-> !BIT_CLOCK && !LOCKED && !SLOW_ACTIVE;
	endproperty
	a_ana: assert property (p_ana) else $error("analog");
	property p_hold;
		FIFO_VALID && !FIFO_READY && DIGITAL_MODE |=> FIFO_VALID && $stable(FIFO_DATA);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_take;
		FIFO_VALID && FIFO_READY |=> !FIFO_VALID;
	endproperty
	a_take: assert property (p_take) else $error("take");
	property p_fast;
		(RECOVERY_MODE == 2'h0) [*3] |-> !SLOW_ACTIVE;
	endproperty
	a_fast: assert property (p_fast) else $error("fast");
	property p_slow;
		(DIGITAL_MODE && RECOVERY_MODE == 2'h1) [*3] |-> SLOW_ACTIVE;
	endproperty
	a_slow: assert property (p_slow) else $error("slow");
	property p_auto;
		s_auto_lock |-> ##[0:2] SLOW_ACTIVE;
	endproperty
	a_auto: assert property (p_auto) else $error("auto");
	property p_dout;
		(DIGITAL_MODE && FIFO_ENABLE) [*3] |-> !DATA_OUT;
	endproperty
	a_dout: assert property (p_dout) else $error("dout");
endmodule // rxf_filter_asserts
bind rxf_filter rxf_filter_asserts u_chk (.CLK, .RST_N, .OVERSAMPLE_TICK, .DIGITAL_MODE,
	.RECOVERY_MODE, .FIFO_ENABLE, .FIFO_READY, .FIFO_DATA, .FIFO_VALID, .DATA_OUT,
	.BIT_CLOCK, .LOCKED, .SLOW_ACTIVE);

// file: tb/rxf_demod_model.sv
// demodulator model: oversample ticks and alternating raw bits
`timescale 1ns/1ps
module rxf_demod_model (
	input wire clk,
	output reg tick = 1'b0,
	output reg raw = 1'b0
);
	reg [4:0] phase = 5'h00;
	always @(posedge clk)
	begin
		tick <= ~tick;
		if (tick)
			phase <= (phase == 5'h1C) ? 5'h00 : phase + 5'h01;
		if (tick && phase == 5'h1C)
			raw <= ~raw;
	end
endmodule // rxf_demod_model

// file: tb/rxf_filter_tb_top.sv
// self-checking bench for the receive data filter
`timescale 1ns/1ps
module rxf_filter_tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg dig = 1'b1;
	reg fen = 1'b1;
	reg rdy = 1'b1;
	reg sliced = 1'b0;
	reg alt = 1'b0;
	reg last = 1'b0;
	reg ovr = 1'b0;
	reg bseen = 1'b0;
	reg [1:0] mode = 2'h0;
	wire tick, raw, fdata, fvalid, fovr, dout, bclk, lock, slow;
	integer num_errors = 0;
	integer tests_run = 0;
	rxf_demod_model u_dem (.clk(clk), .tick(tick), .raw(raw));
	rxf_filter dut (.CLK(clk), .RST_N(rst_n), .RAW_DATA(raw), .SLICED_DATA(sliced),
		.OVERSAMPLE_TICK(tick), .DIGITAL_MODE(dig), .RECOVERY_MODE(mode), .FIFO_ENABLE(fen),
		.FIFO_READY(rdy), .FIFO_DATA(fdata), .FIFO_VALID(fvalid), .FIFO_OVERRUN(fovr),
		.DATA_OUT(dout), .BIT_CLOCK(bclk), .LOCKED(lock), .SLOW_ACTIVE(slow));
	initial forever #50 clk = ~clk;
	task chk(input [63:0] name, input exp, input got);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0s expected %b seen %b", name, exp, got);
		end
	end
	endtask
	task step(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	always @(posedge clk)
	begin
		if (fovr)
			ovr <= 1'b1;
		if (bclk)
			bseen <= 1'b1;
		if (alt && fvalid && rdy)
			chk("alt", ~last, fdata);
		if (fvalid && rdy)
			last <= fdata;
	end
	initial
	begin
		step(4);
		rst_n = 1'b1;
		step(1200);
		alt = 1'b1;
		step(600);
		alt = 1'b0;
		chk("lock", 1'b1, lock);
		chk("bclk", 1'b1, bseen);
		chk("slow", 1'b0, slow);
		chk("dout", 1'b0, dout);
		mode = 2'h2;
		step(1500);
		chk("auto", 1'b1, slow);
		mode = 2'h1;
		step(200);
		chk("slowm", 1'b1, slow);
		rdy = 1'b0;
		step(600);
		chk("full", 1'b1, fvalid);
		chk("ovr", 1'b1, ovr);
		rdy = 1'b1;
		step(20);
		fen = 1'b0;
		@(raw);
		step(30);
		chk("filt", raw, dout);
		dig = 1'b0;
		sliced = 1'b1;
		step(20);
		chk("ana", 1'b1, dout);
		chk("aclk", 1'b0, bclk);
		sliced = 1'b0;
		step(20);
		chk("ana0", 1'b0, dout);
		complete_run;
	end
	initial
	begin
		#2000000;
		num_errors = num_errors + 1;
		complete_run;
	end
endmodule // rxf_filter_tb_top
